// file: ivm_top.sv
// interrupt vector map with enables, wake logic and register port
//
// The plain strobed port and the register offsets were chosen for this implementation.
`include "ivm_consts.svh"
`timescale 1ns/10ps
module ivm_top
    import ivm_pkg::*;
#(
    parameter int NUM_SRC = `IVM_NUM_SRC
) (
    input  wire logic                    i_clock,
    input  wire logic                    i_rst,
    input  wire logic [`IVM_ADDR_W-1:0]  i_addr,
    input  wire logic [`IVM_DATA_W-1:0]  i_wdata,
    input  wire logic                    i_wr,
    input  wire logic                    i_rd,
    output logic [`IVM_DATA_W-1:0]       o_rdata,
    input  wire logic [15:0]             i_serial_flags,
    input  wire logic                    i_api_flag,
    input  wire logic [7:0]              i_pit_flags,
    input  wire logic [7:0]              i_coproc_trig,
    input  wire logic [2:0]              i_timer_flags,
    output ivm_req_s                     o_req,
    output ivm_wake_s                    o_wake,
    output logic                         o_irq
);

    // =============================================================
    // check
    if (NUM_SRC != `IVM_NUM_SRC) begin : g_chk
        $error("ivm_top serves exactly the fixed source table");
    end

    localparam int IW = $clog2(NUM_SRC);
    localparam logic [8*NUM_SRC-1:0] VEC_TBL = `IVM_VEC_TABLE;
    localparam logic [8*NUM_SRC-1:0] CHN_TBL = `IVM_CHN_TABLE;
    localparam logic [NUM_SRC-1:0]   STOP_CAP = `IVM_STOP_CAP;

    // =============================================================
    // registers
    logic [7:0]              vbase_reg;
    logic [7:0]              vbase_next;
    logic [15:0]             ser_en_reg;
    logic [15:0]             ser_en_next;
    logic                    api_en_reg;
    logic                    api_en_next;
    logic                    coproc_en_reg;
    logic                    coproc_en_next;
    logic [2:0]              tim_en_reg;
    logic [2:0]              tim_en_next;
    logic [7:0]              pit_en_reg;
    logic [7:0]              pit_en_next;
    logic [`IVM_ST_W-1:0]    status_reg;
    logic [`IVM_ST_W-1:0]    status_next;
    logic [`IVM_ST_W-1:0]    mask_reg;
    logic [`IVM_ST_W-1:0]    mask_next;
    logic [`IVM_DATA_W-1:0]  rdata_reg;
    logic [`IVM_DATA_W-1:0]  rdata_next;
    ivm_req_s                req_reg;
    ivm_req_s                req_next;
    ivm_wake_s               wake_reg;
    ivm_wake_s               wake_next;

    logic [NUM_SRC-1:0]      src_req;
    logic                    pick_valid;
    logic [IW-1:0]           pick_index;
    logic [`IVM_ST_W-1:0]    events;

    // =============================================================
    // source gating
    genvar g;
    for (g = 0; g < `IVM_NUM_SER; g++) begin : g_ser
        assign src_req[g] =
            |(i_serial_flags[4*g +: 4] & ser_en_reg[4*g +: 4]); // [R1]
    end
    assign src_req[4] = i_api_flag & api_en_reg; // [R2]
    for (g = 0; g < 4; g++) begin : g_pit
        assign src_req[5 + g]  = i_pit_flags[g] & pit_en_reg[g]; // [R3]
        assign src_req[17 + g] =
            i_pit_flags[4 + g] & pit_en_reg[4 + g]; // [R4]
    end
    for (g = 0; g < `IVM_NUM_TRIG; g++) begin : g_trig
        assign src_req[9 + g] = i_coproc_trig[g] & coproc_en_reg; // [R5] [R6]
    end
    for (g = 0; g < `IVM_NUM_TIM; g++) begin : g_tim
        assign src_req[21 + g] = i_timer_flags[g] & tim_en_reg[g]; // [R7]
    end

    // =============================================================
    // priority pick
    ivm_prio #(
        .N       (NUM_SRC)
    ) u_prio (
        .i_req   (src_req),
        .o_valid (pick_valid),
        .o_index (pick_index)
    );

    // =============================================================
    // request and wake outputs
    always_comb begin
        req_next.valid   = pick_valid;
        req_next.vector  = {vbase_reg, VEC_TBL[pick_index*8 +: 8]}; // [R1]
        req_next.channel = CHN_TBL[pick_index*8 +: 8]; // [R1]
        if (!pick_valid) begin
            req_next.vector  = 16'h0000;
            req_next.channel = 8'h00;
        end
        wake_next.stop_wake = |(src_req & STOP_CAP); // [R1] [R2]
        wake_next.wait_wake = |src_req; // [R4] [R5] [R7]
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            req_reg  <= '0;
            wake_reg <= '0;
        end else begin
            req_reg  <= req_next;
            wake_reg <= wake_next;
        end
    end

    // =============================================================
    // events on rising request and wake levels
    always_comb begin
        events                = '0;
        events[`IVM_ST_REQ]   = req_next.valid & ~req_reg.valid;
        events[`IVM_ST_STOP]  = wake_next.stop_wake & ~wake_reg.stop_wake;
        events[`IVM_ST_WAIT]  = wake_next.wait_wake & ~wake_reg.wait_wake;
    end

    // =============================================================
    // register port
    always_comb begin
        vbase_next     = vbase_reg;
        ser_en_next    = ser_en_reg;
        api_en_next    = api_en_reg;
        coproc_en_next = coproc_en_reg;
        tim_en_next    = tim_en_reg;
        pit_en_next    = pit_en_reg;
        mask_next      = mask_reg;
        status_next    = status_reg;
        rdata_next     = '0;
        if (i_wr) begin
            case (i_addr)
                `IVM_A_VBASE: begin
                    vbase_next = i_wdata[15:8];
                end
                `IVM_A_SER_EN: begin
                    ser_en_next = i_wdata[15:0];
                end
                `IVM_A_MISC_EN: begin
                    api_en_next    = i_wdata[`IVM_F_API_EN];
                    coproc_en_next = i_wdata[`IVM_F_COPROC_EN];
                    tim_en_next    = i_wdata[`IVM_F_TIM_EN +: 3];
                end
                `IVM_A_PIT_EN: begin
                    pit_en_next = i_wdata[7:0];
                end
                `IVM_A_STATUS: begin
                    status_next = status_reg & ~i_wdata[`IVM_ST_W-1:0];
                end
                `IVM_A_MASK: begin
                    mask_next = i_wdata[`IVM_ST_W-1:0];
                end
                default: begin
                    mask_next = mask_reg;
                end
            endcase
        end
        status_next = status_next | events;
        if (i_rd) begin
            case (i_addr)
                `IVM_A_VBASE: begin
                    rdata_next[15:8] = vbase_reg;
                end
                `IVM_A_SER_EN: begin
                    rdata_next[15:0] = ser_en_reg;
                end
                `IVM_A_MISC_EN: begin
                    rdata_next[`IVM_F_API_EN]    = api_en_reg;
                    rdata_next[`IVM_F_COPROC_EN] = coproc_en_reg;
                    rdata_next[`IVM_F_TIM_EN +: 3] = tim_en_reg;
                end
                `IVM_A_PIT_EN: begin
                    rdata_next[7:0] = pit_en_reg;
                end
                `IVM_A_PENDING: begin
                    rdata_next[NUM_SRC-1:0] = src_req;
                end
                `IVM_A_VECTOR: begin
                    rdata_next[24:0] = {req_reg.valid, req_reg.channel,
                                        req_reg.vector};
                end
                `IVM_A_STATUS: begin
                    rdata_next[`IVM_ST_W-1:0] = status_reg;
                end
                `IVM_A_MASK: begin
                    rdata_next[`IVM_ST_W-1:0] = mask_reg;
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            vbase_reg     <= `IVM_RST_VBASE;
            ser_en_reg    <= `IVM_RST_EN16;
            api_en_reg    <= 1'b0;
            coproc_en_reg <= 1'b0;
            tim_en_reg    <= `IVM_RST_EN3;
            pit_en_reg    <= `IVM_RST_EN8;
            status_reg    <= '0;
            mask_reg      <= '0;
            rdata_reg     <= '0;
        end else begin
            vbase_reg     <= vbase_next;
            ser_en_reg    <= ser_en_next;
            api_en_reg    <= api_en_next;
            coproc_en_reg <= coproc_en_next;
            tim_en_reg    <= tim_en_next;
            pit_en_reg    <= pit_en_next;
            status_reg    <= status_next;
            mask_reg      <= mask_next;
            rdata_reg     <= rdata_next;
        end
    end

    // =============================================================
    // outputs
    assign o_rdata = rdata_reg;
    assign o_req   = req_reg;
    assign o_wake  = wake_reg;
    assign o_irq   = |(status_reg & mask_reg);

endmodule // ivm_top

// file: ivm_consts.svh
// constants and register map of the interrupt vector map
// How it works
// [R1] serial ch2-5: vectors 8A-84, ids 45-42, four enables, stop+wait wake
// [R2] autonomous periodic irq: vector 7E, id 3F, own enable, stop+wait wake
// [R3] periodic timer ch0-3: vectors 7A-74, ids 3D-3A, own enable, wait only
// [R4] periodic timer ch4-7: vectors 5E-58, ids 2F-2C, own enable, wait only
// [R5] coproc triggers 0-3: vectors 72-6C, ids 39-36, shared enable, wait only
// [R6] coproc triggers 4-7: vectors 6A-64, ids 35-32, shared enable, wait only
// [R7] standard timer ch0-2: vectors 54-50, ids 2A-28, own enable, wait only
`ifndef IVM_CONSTS_SVH
`define IVM_CONSTS_SVH

// =============================================================
// sizes
`define IVM_NUM_SRC      24
`define IVM_DATA_W       32
`define IVM_ADDR_W       4
`define IVM_NUM_SER      4
`define IVM_NUM_PIT      8
`define IVM_NUM_TRIG     8
`define IVM_NUM_TIM      3

// =============================================================
// register offsets
`define IVM_A_VBASE      4'h0
`define IVM_A_SER_EN     4'h1
`define IVM_A_MISC_EN    4'h2
`define IVM_A_PIT_EN     4'h3
`define IVM_A_PENDING    4'h4
`define IVM_A_VECTOR     4'h5
`define IVM_A_STATUS     4'h6
`define IVM_A_MASK       4'h7

// =============================================================
// field positions and reset values
`define IVM_F_API_EN     0
`define IVM_F_COPROC_EN  1
`define IVM_F_TIM_EN     2
`define IVM_RST_VBASE    8'hFF
`define IVM_RST_EN16     16'h0000
`define IVM_RST_EN8      8'h00
`define IVM_RST_EN3      3'h0
`define IVM_ST_REQ       0
`define IVM_ST_STOP      1
`define IVM_ST_WAIT      2
`define IVM_ST_W         3

// =============================================================
// source tables, source 0 (highest priority) in the low byte
`define IVM_VEC_TABLE {8'h50, 8'h52, 8'h54, 8'h58, 8'h5A, 8'h5C, 8'h5E, \
    8'h64, 8'h66, 8'h68, 8'h6A, 8'h6C, 8'h6E, 8'h70, 8'h72, \
    8'h74, 8'h76, 8'h78, 8'h7A, 8'h7E, 8'h84, 8'h86, 8'h88, 8'h8A}
`define IVM_CHN_TABLE {8'h28, 8'h29, 8'h2A, 8'h2C, 8'h2D, 8'h2E, 8'h2F, \
    8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, \
    8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h3F, 8'h42, 8'h43, 8'h44, 8'h45}
`define IVM_STOP_CAP     24'h00001F

`endif

// file: ivm_pkg.sv
// types of the interrupt vector map
package ivm_pkg;

    // =============================================================
    // request handed to the cpu and coprocessor
    typedef struct packed {
        logic       valid;
        logic [15:0] vector;
        logic [7:0] channel;
    } ivm_req_s;

    // =============================================================
    // wake-up indications
    typedef struct packed {
        logic stop_wake;
        logic wait_wake;
    } ivm_wake_s;

endpackage

// file: ivm_prio.sv
// fixed priority picker, lowest index wins
`timescale 1ns/10ps
module ivm_prio #(
    parameter int N = 24
) (
    input  wire logic [N-1:0]         i_req,
    output logic                      o_valid,
    output logic [$clog2(N)-1:0]      o_index
);

    // =============================================================
    // check
    if (N < 2) begin : g_chk
        $error("ivm_prio needs at least two inputs");
    end

    // =============================================================
    // search from the lowest priority upward
    always_comb begin
        o_valid = 1'b0;
        o_index = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (i_req[i]) begin
                o_valid = 1'b1;
                o_index = ($clog2(N))'(i);
            end
        end
    end

endmodule // ivm_prio

// file: ivm_cpu_model.sv
// behavioural receiver of the vectored requests
`timescale 1ns/10ps
module ivm_cpu_model
    import ivm_pkg::*;
(
    input  wire logic     i_clock,
    input  wire logic     i_rst,
    input  wire ivm_req_s i_req,
    output ivm_req_s      o_last
);
    // =============================================================
    // keeps the last request taken
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_last <= '0;
        end else if (i_req.valid) begin
            o_last <= i_req;
        end
    end
endmodule // ivm_cpu_model

// file: ivm_checker_assertions.sv
// port assertions of the interrupt vector map
`include "ivm_consts.svh"
`timescale 1ns/10ps
module ivm_checker
    import ivm_pkg::*;
#(
    parameter int NUM_SRC = 24
) (
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [15:0] i_serial_flags,
    input wire logic        i_api_flag,
    input wire logic [7:0]  i_pit_flags,
    input wire logic [7:0]  i_coproc_trig,
    input wire logic [2:0]  i_timer_flags,
    input wire ivm_req_s    o_req,
    input wire ivm_wake_s   o_wake,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    logic [7:0] off;
    logic       v;
    assign off = o_req.vector[7:0];
    assign v = o_req.valid;
    // =============================================================
    // vector and channel pairs
    a_ser_pair: assert property (
        v && off == 8'h8A |-> o_req.channel == 8'h45)
        else $error("serial channel id wrong");
    a_api_pair: assert property (
        v && off == 8'h7E |-> o_req.channel == 8'h3F)
        else $error("periodic irq channel id wrong");
    a_pit_low: assert property (
        v && off == 8'h7A |-> o_req.channel == 8'h3D)
        else $error("pit low channel id wrong");
    a_pit_high: assert property (
        v && off == 8'h5E |-> o_req.channel == 8'h2F)
        else $error("pit high channel id wrong");
    a_trig_low: assert property (
        v && off == 8'h72 |-> o_req.channel == 8'h39)
        else $error("trigger low channel id wrong");
    a_trig_high: assert property (
        v && off == 8'h6A |-> o_req.channel == 8'h35)
        else $error("trigger high channel id wrong");
    a_tim_pair: assert property (
        v && off == 8'h54 |-> o_req.channel == 8'h2A)
        else $error("timer channel id wrong");
    // =============================================================
    // wake and idle relations
    a_stop_wake: assert property (
        v && off >= 8'h7E |-> o_wake == 2'h3)
        else $error("stop wake missing");
    a_wait_only: assert property (
        v && off < 8'h7E |-> o_wake == 2'h1)
        else $error("wait only source woke stop");
    a_idle_quiet: assert property ((i_serial_flags == 16'h0
        && !i_api_flag && i_pit_flags == 8'h0
        && i_coproc_trig == 8'h0 && i_timer_flags == 3'h0)
        |=> !o_req.valid && o_wake == 2'h0)
        else $error("request without flag");
    a_idle_zero: assert property (!v |-> o_req.vector == 16'h0
        && o_req.channel == 8'h0) else $error("idle request not zero");
    a_rdata_gap: assert property (!i_rd |=> o_rdata == 32'h0)
        else $error("read data outside its cycle");
    a_reset_clear: assert property (disable iff (1'h0) i_rst |=> o_req == '0
        && o_wake == 2'h0 && !o_irq) else $error("reset did not clear");
    c_stop: cover property (o_wake.stop_wake);
    c_irq: cover property (o_irq);
    c_tim: cover property (v && off == 8'h50);
endmodule // ivm_checker

bind ivm_top ivm_checker #(.NUM_SRC(NUM_SRC)) i_ivm_checker (
    .i_clock(i_clock), .i_rst(i_rst), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_serial_flags(i_serial_flags), .i_api_flag(i_api_flag),
    .i_pit_flags(i_pit_flags), .i_coproc_trig(i_coproc_trig),
    .i_timer_flags(i_timer_flags), .o_req(o_req), .o_wake(o_wake),
    .o_irq(o_irq));

// file: tb_top.sv
// self-checking bench of the interrupt vector map
`include "ivm_consts.svh"
`timescale 1ns/10ps
module tb_top;
    import ivm_pkg::*;
    typedef struct packed {
        logic [3:0]  a;
        logic [31:0] en;
        logic [35:0] f;
        logic [7:0]  off;
        logic [7:0]  chn;
        logic        stp;
    } ivm_row_s;
    ivm_row_s    rows [13] = '{
        '{4'h1, 32'h1, 36'h1, 8'h8A, 8'h45, 1'h1},
        '{4'h1, 32'h8000, 36'h8000, 8'h84, 8'h42, 1'h1},
        '{4'h2, 32'h1, 36'h10000, 8'h7E, 8'h3F, 1'h1},
        '{4'h3, 32'h1, 36'h20000, 8'h7A, 8'h3D, 1'h0},
        '{4'h3, 32'h8, 36'h100000, 8'h74, 8'h3A, 1'h0},
        '{4'h3, 32'h10, 36'h200000, 8'h5E, 8'h2F, 1'h0},
        '{4'h3, 32'h80, 36'h1000000, 8'h58, 8'h2C, 1'h0},
        '{4'h2, 32'h2, 36'h2000000, 8'h72, 8'h39, 1'h0},
        '{4'h2, 32'h2, 36'h10000000, 8'h6C, 8'h36, 1'h0},
        '{4'h2, 32'h2, 36'h20000000, 8'h6A, 8'h35, 1'h0},
        '{4'h2, 32'h2, 36'h100000000, 8'h64, 8'h32, 1'h0},
        '{4'h2, 32'h4, 36'h200000000, 8'h54, 8'h2A, 1'h0},
        '{4'h2, 32'h10, 36'h800000000, 8'h50, 8'h28, 1'h0}};
    logic        i_clock = 1'h0, i_rst = 1'h1, i_wr = 1'h0, i_rd = 1'h0;
    logic [3:0]  i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic [35:0] fl = 36'h0;
    logic [7:0]  vb = 8'hFF;
    logic        o_irq;
    ivm_req_s    o_req, last;
    ivm_wake_s   o_wake;
    int          bad_count = 0, compares = 0;
    ivm_top i_ivm_top (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_serial_flags(fl[15:0]), .i_api_flag(fl[16]),
        .i_pit_flags(fl[24:17]), .i_coproc_trig(fl[32:25]),
        .i_timer_flags(fl[35:33]), .o_req(o_req), .o_wake(o_wake),
        .o_irq(o_irq));
    ivm_cpu_model i_ivm_cpu_model (.i_clock(i_clock), .i_rst(i_rst),
        .i_req(o_req), .o_last(last));
    task automatic chk(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr <= 1'h1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'h0;
    endtask
    task automatic rdc(input string n, input logic [3:0] a, logic [31:0] e);
        @(posedge i_clock);
        i_rd <= 1'h1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'h0;
        #1 chk(n, e, o_rdata);
    endtask
    task automatic setf(input logic [35:0] v);
        @(posedge i_clock);
        fl <= v;
        @(posedge i_clock);
        #1;
    endtask
    task automatic chkreq(input logic v, input logic [7:0] o, c, logic s);
        chk("req", {7'h0, v, v ? vb : 8'h0, o, c}, {7'h0, o_req});
        chk("wake", {30'h0, s, v}, {30'h0, o_wake});
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        forever #2.5 i_clock = ~i_clock;
    end
    initial begin
        #100us;
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge i_clock);
        i_rst <= 1'h0;
        rdc("vbase", `IVM_A_VBASE, 32'h0000FF00);
        rdc("ser_en", `IVM_A_SER_EN, 32'h0);
        rdc("unmapped", 4'h9, 32'h0);
        wr(`IVM_A_VBASE, 32'h1200);
        vb = 8'h12;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].en);
            setf(rows[i].f);
            chkreq(1'h1, rows[i].off, rows[i].chn,
                rows[i].stp);
            setf(36'h0);
            chkreq(1'h0, 8'h0, 8'h0, 1'h0);
            chk("cpu", {8'h0, vb, rows[i].off, rows[i].chn},
                {8'h0, last.vector,
                last.channel});
            wr(rows[i].a, 32'h0);
        end
        // disabled source, then priority order
        setf(36'h1);
        chkreq(1'h0, 8'h0, 8'h0, 1'h0);
        wr(`IVM_A_SER_EN, 32'h1);
        wr(`IVM_A_MISC_EN, 32'h4);
        setf(36'h200000001);
        chkreq(1'h1, 8'h8A, 8'h45, 1'h1);
        rdc("pending", `IVM_A_PENDING, 32'h00200001);
        rdc("vector", `IVM_A_VECTOR, 32'h0145128A);
        setf(36'h200000000);
        chkreq(1'h1, 8'h54, 8'h2A, 1'h0);
        rdc("misc_en", `IVM_A_MISC_EN, 32'h4);
        // interrupt raised, cleared, masked
        wr(`IVM_A_STATUS, 32'h7);
        setf(36'h0);
        wr(`IVM_A_MASK, 32'h1);
        rdc("mask", `IVM_A_MASK, 32'h1);
        setf(36'h200000000);
        chk("irq", 32'h1, {31'h0, o_irq});
        rdc("status", `IVM_A_STATUS, 32'h5);
        setf(36'h0);
        wr(`IVM_A_STATUS, 32'h7);
        #1 chk("irq_clr", 32'h0, {31'h0, o_irq});
        wr(`IVM_A_MASK, 32'h0);
        setf(36'h200000000);
        chk("irq_mask", 32'h0, {31'h0, o_irq});
        // reset in mid-run
        @(posedge i_clock);
        i_rst <= 1'h1;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'h0;
        #1 chkreq(1'h0, 8'h0, 8'h0, 1'h0);
        rdc("vbase_rst", `IVM_A_VBASE, 32'h0000FF00);
        chkreq(1'h0, 8'h0, 8'h0, 1'h0);
        chk("irq_rst", 32'h0, {31'h0, o_irq});
        report_and_stop();
    end
endmodule // tb_top
